// File: bench/bdc_command_engine_properties.sv
`timescale 1ns/1ps
module bdc_engine_checker (
   input wire logic                     ref_clk,
   input wire logic                     rst_n,
   input wire logic                     coreHalted,
   input wire logic                     resumePulse,
   input wire bdc_pkg::bdc_reg_req_type regReq,
   input wire logic                     regAck,
   input wire bdc_pkg::bdc_mem_req_type memReq,
   input wire logic                     memAck,
   input wire logic                     transferErrorAck,
   input wire logic                     avs_read,
   input wire logic                     avs_write,
   input wire logic [3:0]               avs_address,
   input wire logic [31:0]              avs_readdata,
   input wire logic                     avs_waitrequest
);
   import bdc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   mem_hold_a: assert property (memReq.req && !(memAck || transferErrorAck) |=>
      memReq.req && $stable(memReq)) else $error("memory request dropped early");
   mem_release_a: assert property (memReq.req && (memAck || transferErrorAck) |=>
      !memReq.req) else $error("memory request outlived its ack");
   word_align_a: assert property (memReq.req && memReq.size == SIZE_WORD |->
      !memReq.addr[0]) else $error("odd word address");
   long_align_a: assert property (memReq.req && memReq.size == SIZE_LONG |->
      memReq.addr[1:0] == 2'h0) else $error("unaligned long address");
   size_legal_a: assert property (memReq.req |-> memReq.size != SIZE_RSVD)
      else $error("reserved size reached the bus");
   reg_halt_a: assert property (regReq.req |-> coreHalted)
      else $error("register access on running core");
   reg_hold_a: assert property (regReq.req && !regAck |=> regReq.req && $stable(regReq))
      else $error("register request changed before ack");
   resume_pulse_a: assert property (resumePulse |-> $past(coreHalted) ##1 !resumePulse)
      else $error("bad resume pulse");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late or long");
   unmapped_zero_a: assert property (avs_read && avs_address == 4'hc && avs_waitrequest |=>
      avs_readdata == 32'h0) else $error("unmapped read not zero");
   cover property (memReq.req && memReq.write);
   cover property (memReq.req && transferErrorAck);
   cover property (regReq.req && regAck);
   cover property (resumePulse);
endmodule // bdc_engine_checker

bind bdc_command_engine bdc_engine_checker bdc_engine_checker_inst (.ref_clk, .rst_n,
   .coreHalted, .resumePulse, .regReq, .regAck, .memReq, .memAck, .transferErrorAck,
   .avs_read, .avs_write, .avs_address, .avs_readdata, .avs_waitrequest);

// File: bench/bdc_command_engine_tb.sv
`timescale 1ns/1ps
module bdc_command_engine_tb;
   import bdc_pkg::*;
   logic            ref_clk = 0, rst_n = 0, coreHalted = 0, regAck = 0, memAck = 0;
   logic            transferErrorAck = 0, avs_read = 0, avs_write = 0;
   logic [31:0]     regRdata = 0, memRdata = 0, avs_writedata = 0, avs_readdata, d, e;
   logic [3:0]      avs_address = 0;
   logic            serialClk, serialIn, serialOut, resumePulse, avs_waitrequest, respValid;
   logic [16:0]     resp, nextExp = RESP_DONE;
   bdc_reg_req_type regReq, regQ[$];
   bdc_mem_req_type memReq, memQ[$];
   logic [16:0]     respQ[$];
   logic [31:0]     avsQ[$];
   int              fails = 0, checks = 0, resumes = 0, seed = 32'h035a5fd3, slow = 0, busErr = 0;
   always #50 ref_clk = ~ref_clk;
   bdc_command_engine bdc_command_engine_inst (.ref_clk, .rst_n, .serialClk, .serialIn,
      .serialOut, .coreHalted, .resumePulse, .regReq, .regAck, .regRdata, .memReq, .memAck,
      .transferErrorAck, .memRdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest);
   bdc_host_model bdc_host_model_inst (.ref_clk, .serialOut, .serialClk, .serialIn,
      .respValid, .resp);
   task automatic bad(input string m);
      fails++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chkResp(input logic [16:0] g, x);
      checks++;
      if (g !== x) bad($sformatf("response %h, want %h", g, x));
   endtask
   task automatic chkWord(input logic [31:0] g, x);
      checks++;
      if (g !== x) bad($sformatf("word %h, want %h", g, x));
   endtask
   task automatic chkMem(input bdc_mem_req_type g, x);
      logic [31:0] k;
      k = x.size == SIZE_BYTE ? 32'hff : x.size == SIZE_WORD ? 32'hffff : 32'hffffffff;
      k = x.write ? k : 32'h0;
      checks++;
      if ({g.write, g.size, g.attr, g.addr, g.wdata & k} !==
          {x.write, x.size, x.attr, x.addr, x.wdata & k}) bad("memory request");
   endtask
   task automatic chkReg(input bdc_reg_req_type g, x);
      checks++;
      if ({g.write, g.isAddr, g.num, g.wdata & {32{x.write}}} !==
          {x.write, x.isAddr, x.num, x.wdata & {32{x.write}}}) bad("register request");
   endtask
   function automatic bdc_mem_req_type mreq(logic w, logic [1:0] s, logic [31:0] a, x);
      return '{1'b1, w, s, 5'h15, a, x};
   endfunction
   task automatic finish_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] v);
      int n;
      if (!wr) avsQ.push_back(v);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= wr;
      avs_read <= !wr;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         bad("bus timeout");
         finish_test();
      end
      {avs_read, avs_write} <= 2'b00;
      @(posedge ref_clk);
   endtask
   // Expectation given is what the following frame must carry
   task automatic tx(input logic [15:0] w, input logic [16:0] r);
      respQ.push_back(nextExp);
      nextExp = r;
      bdc_host_model_inst.xfer(w);
   endtask
   always @(posedge ref_clk) begin
      if (respValid === 1'b1) begin
         if (respQ.size() == 0) bad("unexpected frame");
         else chkResp(resp, respQ.pop_front());
      end
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chkWord(avs_readdata, avsQ.pop_front());
      if (resumePulse === 1'b1) resumes++;
   end
   // Slow answers hold each memory access for 40 clocks, well inside one frame
   always begin
      @(posedge ref_clk);
      if (memReq.req === 1'b1) begin
         if (memQ.size() == 0) bad("unexpected memory cycle");
         else chkMem(memReq, memQ.pop_front());
         repeat (slow ? 40 : 1 + $unsigned($random(seed)) % 4) @(posedge ref_clk);
         {memAck, transferErrorAck} <= {busErr == 0, busErr != 0};
         memRdata <= d;
         @(posedge ref_clk);
         {memAck, transferErrorAck} <= 2'b00;
         memRdata <= ~d;
      end
   end
   always begin
      @(posedge ref_clk);
      if (regReq.req === 1'b1) begin
         if (regQ.size() == 0) bad("unexpected register access");
         else chkReg(regReq, regQ.pop_front());
         repeat (40) @(posedge ref_clk);
         regAck <= 1'b1;
         regRdata <= e;
         @(posedge ref_clk);
         regAck <= 1'b0;
         regRdata <= ~e;
      end
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad("run timeout");
      finish_test();
   end
   initial begin
      static logic [15:0] ill [6] = '{16'h0200, 16'h0020, 16'hfc00, 16'h19c0, 16'h1dc0,
                                      16'h2980};
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      avs(1, OFS_ATTR, 32'hffffffd5);
      avs(0, OFS_ATTR, 32'h15);
      avs(0, 4'hc, 32'h0);
      tx(16'h0000, RESP_DONE);
      foreach (ill[i]) tx(ill[i], RESP_ILLEGAL);
      tx(16'h0000, RESP_DONE);
      $display("test commands done");
      d = $random(seed);
      memQ.push_back(mreq(0, SIZE_LONG, 32'h12345674, 0));
      tx(16'h1980, RESP_NOT_READY);
      tx(16'h1234, RESP_NOT_READY);
      tx(16'h5677, {1'b0, d[31:16]});
      tx(16'h0000, {1'b0, d[15:0]});
      tx(16'h0000, RESP_DONE);
      slow = 1;
      d = $random(seed);
      memQ.push_back(mreq(0, SIZE_WORD, 32'h12345678, 0));
      tx(16'h1d40, RESP_NOT_READY);
      tx(16'h0000, {1'b0, d[15:0]});
      tx(16'h0000, RESP_DONE);
      busErr = 1;
      memQ.push_back(mreq(0, SIZE_BYTE, 32'h00abcdef, 0));
      tx(16'h1900, RESP_NOT_READY);
      tx(16'h00ab, RESP_NOT_READY);
      tx(16'hcdef, RESP_NOT_READY);
      tx(16'h0000, RESP_BUS_ERR);
      tx(16'h0000, RESP_DONE);
      busErr = 0;
      d = $random(seed);
      memQ.push_back(mreq(0, SIZE_BYTE, 32'h00abcdf0, 0));
      tx(16'h1d00, RESP_NOT_READY);
      tx(16'h0000, {9'h0, d[7:0]});
      tx(16'h0000, RESP_DONE);
      $display("test memory read done");
      d = $random(seed);
      e = $random(seed);
      memQ.push_back(mreq(1, SIZE_LONG, 32'h40000000, d));
      memQ.push_back(mreq(1, SIZE_WORD, 32'h40000004, e));
      tx(16'h1880, RESP_NOT_READY);
      tx(16'h4000, RESP_NOT_READY);
      tx(16'h0002, RESP_NOT_READY);
      tx(d[31:16], RESP_NOT_READY);
      tx(d[15:0], RESP_NOT_READY);
      tx(16'h0000, RESP_DONE);
      tx(16'h1c40, RESP_NOT_READY);
      tx(e[15:0], RESP_NOT_READY);
      tx(16'h0000, RESP_DONE);
      $display("test memory write done");
      tx(16'h0c00, RESP_BUS_ERR);
      tx(16'h2105, RESP_BUS_ERR);
      tx(16'h0000, RESP_DONE);
      coreHalted <= 1'b1;
      d = $random(seed);
      e = $random(seed);
      regQ.push_back('{1'b1, 1'b1, 1'b0, 3'h3, d});
      regQ.push_back('{1'b1, 1'b0, 1'b1, 3'h5, 32'h0});
      tx(16'h2003, RESP_NOT_READY);
      tx(d[31:16], RESP_NOT_READY);
      tx(d[15:0], RESP_NOT_READY);
      tx(16'h0000, RESP_DONE);
      tx(16'h1c40, RESP_ILLEGAL);
      tx(16'h0000, RESP_DONE);
      tx(16'h210d, RESP_NOT_READY);
      tx(16'h0000, {1'b0, e[31:16]});
      tx(16'h0000, {1'b0, e[15:0]});
      tx(16'h0c00, RESP_DONE);
      tx(16'h0000, RESP_DONE);
      avs(0, OFS_TEMP_ADDR, 32'h40000006);
      avs(0, OFS_STATUS, 32'h0);
      chkWord(resumes, 32'h1);
      chkWord(respQ.size() + memQ.size() + regQ.size(), 32'h0);
      $display("test registers done");
      finish_test();
   end
endmodule // bdc_command_engine_tb

// File: bench/bdc_host_model.sv
`timescale 1ns/1ps
module bdc_host_model (
   input  wire logic        ref_clk,
   input  wire logic        serialOut,
   output logic             serialClk,
   output logic             serialIn,
   output logic             respValid,
   output logic [16:0]      resp
);
   initial begin
      {serialClk, serialIn, respValid, resp} = '0;
   end
   // Clock parked low between frames; 800 ns period inside a frame
   task automatic xfer(input logic [15:0] w);
      logic [16:0] f;
      f = {1'b0, w};
      for (int b = 16; b >= 0; b--) begin
         serialIn <= f[b];
         repeat (4) @(posedge ref_clk);
         serialClk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         resp[b] <= serialOut;
         serialClk <= 1'b0;
      end
      respValid <= 1'b1;
      @(posedge ref_clk);
      respValid <= 1'b0;
      serialIn <= ~f[0];
      // Gap well over eight clocks so an idle device is always ready
      repeat (16) @(posedge ref_clk);
   endtask
endmodule // bdc_host_model

// File: rtl/bdc_command_engine.sv
`timescale 1ns/1ps
module bdc_command_engine (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire logic                     serialClk,
   input  wire logic                     serialIn,
   output logic                          serialOut,
   input  wire logic                     coreHalted,
   output logic                          resumePulse,
   output bdc_pkg::bdc_reg_req_type      regReq,
   input  wire logic                     regAck,
   input  wire logic [31:0]              regRdata,
   output bdc_pkg::bdc_mem_req_type      memReq,
   input  wire logic                     memAck,
   input  wire logic                     transferErrorAck,
   input  wire logic [31:0]              memRdata,
   input  wire logic [3:0]               avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest
);
   import bdc_pkg::*;

   typedef enum logic [2:0] {
      ST_CMD, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_HI, ST_DATA_LO, ST_ACCESS, ST_RESULT_HI
   } bdc_state_type;

   logic          rstMeta, rstSyncN;
   bdc_state_type stateQ;
   logic [16:0]   respQ;
   bdc_cmd_type   cmdQ;
   bdc_cmd_type   rxCmd;
   logic [31:0]   addrQ, dataQ;
   logic          failQ, dumpOkQ, fillOkQ;
   logic          startMemQ, startRegQ;
   logic          accDoneQ, accErrQ, doneNowQ;
   logic [31:0]   accDataQ;
   logic [31:0]   tempBreakAddrQ;
   logic [4:0]    addrAttrQ;
   logic          frameActive, rxValid;
   logic [15:0]   rxWord;
   logic          isLong, accessBusy;

   function automatic logic [31:0] alignAddr(input logic [31:0] a, input logic [1:0] sz);
      logic [31:0] r;
      r = a;
      if (sz == SIZE_WORD) begin
         r[0] = 1'b0;
      end else if (sz == SIZE_LONG) begin
         r[1:0] = 2'h0;
      end
      return r;
   endfunction

   function automatic logic [31:0] sizeStep(input logic [1:0] sz);
      logic [31:0] r;
      r = 32'h00000001;
      if (sz == SIZE_WORD) begin
         r = 32'h00000002;
      end else if (sz == SIZE_LONG) begin
         r = 32'h00000004;
      end
      return r;
   endfunction

   // Assert at once, release through two flops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   bdc_serial_shifter u_shifter (
      .clk         (ref_clk),
      .rstN        (rstSyncN),
      .serClkPin   (serialClk),
      .serInPin    (serialIn),
      .txWord      (respQ),
      .serOut      (serialOut),
      .frameActive (frameActive),
      .rxValid     (rxValid),
      .rxWord      (rxWord)
   );

   assign rxCmd      = bdc_cmd_type'(rxWord);
   assign isLong     = (cmdQ.op == OP_REG) || (cmdQ.size == SIZE_LONG);
   assign accessBusy = memReq.req | regReq.req;

   // Command sequencer; every frame is taken in one cycle, far inside eight clocks
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         stateQ      <= ST_CMD;
         respQ       <= RESP_DONE;
         cmdQ        <= '0;
         addrQ       <= '0;
         dataQ       <= '0;
         failQ       <= 1'b0;
         dumpOkQ     <= 1'b0;
         fillOkQ     <= 1'b0;
         startMemQ   <= 1'b0;
         startRegQ   <= 1'b0;
         resumePulse <= 1'b0;
         doneNowQ    <= 1'b0;
      end else begin
         startMemQ   <= 1'b0;
         startRegQ   <= 1'b0;
         resumePulse <= 1'b0;
         doneNowQ    <= 1'b0;
         case (stateQ)
            ST_CMD: begin
               if (rxValid) begin
                  cmdQ  <= rxCmd;
                  dataQ <= '0;
                  failQ <= 1'b0;
                  respQ <= RESP_ILLEGAL;
                  if (rxCmd.zero9 == 1'b0 && rxCmd.zero54 == 2'h0) begin
                     if (rxCmd.op == OP_NOP) begin
                        respQ <= RESP_DONE;
                     end else if (rxCmd.op == OP_GO) begin
                        dumpOkQ <= 1'b0;
                        fillOkQ <= 1'b0;
                        if (coreHalted) begin
                           resumePulse <= 1'b1;
                           respQ       <= RESP_DONE;
                        end else begin
                           respQ <= RESP_BUS_ERR;
                        end
                     end else if (rxCmd.op == OP_REG) begin
                        dumpOkQ <= 1'b0;
                        fillOkQ <= 1'b0;
                        respQ   <= RESP_NOT_READY;
                        if (rxCmd.rw) begin
                           stateQ    <= ST_ACCESS;
                           failQ     <= !coreHalted;
                           startRegQ <= coreHalted;
                        end else begin
                           stateQ <= ST_DATA_HI;
                        end
                     end else if (rxCmd.op == OP_MEM && rxCmd.size != SIZE_RSVD) begin
                        dumpOkQ <= rxCmd.rw;
                        fillOkQ <= !rxCmd.rw;
                        respQ   <= RESP_NOT_READY;
                        stateQ  <= ST_ADDR_HI;
                     end else if (rxCmd.op == OP_BLOCK && rxCmd.size != SIZE_RSVD) begin
                        if (rxCmd.rw && dumpOkQ) begin
                           respQ     <= RESP_NOT_READY;
                           stateQ    <= ST_ACCESS;
                           startMemQ <= 1'b1;
                        end else if (!rxCmd.rw && fillOkQ) begin
                           respQ  <= RESP_NOT_READY;
                           stateQ <= (rxCmd.size == SIZE_LONG) ? ST_DATA_HI : ST_DATA_LO;
                        end
                     end
                  end
               end
            end
            ST_ADDR_HI: begin
               if (rxValid) begin
                  addrQ[31:16] <= rxWord;
                  respQ        <= RESP_NOT_READY;
                  stateQ       <= ST_ADDR_LO;
               end
            end
            ST_ADDR_LO: begin
               if (rxValid) begin
                  addrQ[15:0] <= rxWord;
                  respQ       <= RESP_NOT_READY;
                  if (cmdQ.rw) begin
                     stateQ    <= ST_ACCESS;
                     startMemQ <= 1'b1;
                  end else begin
                     stateQ <= (cmdQ.size == SIZE_LONG) ? ST_DATA_HI : ST_DATA_LO;
                  end
               end
            end
            ST_DATA_HI: begin
               if (rxValid) begin
                  dataQ[31:16] <= rxWord;
                  respQ        <= RESP_NOT_READY;
                  stateQ       <= ST_DATA_LO;
               end
            end
            ST_DATA_LO: begin
               if (rxValid) begin
                  dataQ[15:0] <= rxWord;
                  respQ       <= RESP_NOT_READY;
                  stateQ      <= ST_ACCESS;
                  if (cmdQ.op == OP_REG) begin
                     failQ     <= !coreHalted;
                     startRegQ <= coreHalted;
                  end else begin
                     startMemQ <= 1'b1;
                  end
               end
            end
            ST_ACCESS: begin
               // Wait for a frame gap so a half-shifted word is not taken as a command
               if (!frameActive && !rxValid && !startMemQ && !startRegQ
                   && (failQ || accDoneQ)) begin
                  stateQ   <= ST_CMD;
                  doneNowQ <= 1'b1;
                  if (failQ || accErrQ) begin
                     respQ <= RESP_BUS_ERR;
                  end else if (!cmdQ.rw) begin
                     respQ <= RESP_DONE;
                  end else if (isLong) begin
                     respQ  <= {1'b0, accDataQ[31:16]};
                     stateQ <= ST_RESULT_HI;
                  end else if (cmdQ.size == SIZE_BYTE) begin
                     respQ <= {1'b0, 8'h00, accDataQ[7:0]};
                  end else begin
                     respQ <= {1'b0, accDataQ[15:0]};
                  end
               end
            end
            ST_RESULT_HI: begin
               if (rxValid) begin
                  respQ  <= {1'b0, accDataQ[15:0]};
                  stateQ <= ST_CMD;
               end
            end
            default: begin
               stateQ <= ST_CMD;
            end
         endcase
         // Frame began on the finishing edge and went out not ready; finish again
         if (doneNowQ && frameActive) begin
            stateQ <= ST_ACCESS;
         end
      end
   end

   // Bus master for memory and core registers
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         memReq   <= '0;
         regReq   <= '0;
         accDoneQ <= 1'b0;
         accErrQ  <= 1'b0;
         accDataQ <= '0;
      end else begin
         if (startMemQ) begin
            accDoneQ     <= 1'b0;
            accErrQ      <= 1'b0;
            memReq.req   <= 1'b1;
            memReq.write <= !cmdQ.rw;
            memReq.size  <= cmdQ.size;
            memReq.attr  <= addrAttrQ;
            memReq.wdata <= dataQ;
            memReq.addr  <= alignAddr((cmdQ.op == OP_BLOCK) ? tempBreakAddrQ : addrQ,
                                      cmdQ.size);
         end else if (memReq.req && (memAck || transferErrorAck)) begin
            memReq.req <= 1'b0;
            accDoneQ   <= 1'b1;
            accErrQ    <= transferErrorAck;
            accDataQ   <= memRdata;
         end
         if (startRegQ) begin
            accDoneQ      <= 1'b0;
            accErrQ       <= 1'b0;
            regReq.req    <= 1'b1;
            regReq.write  <= !cmdQ.rw;
            regReq.isAddr <= cmdQ.isAddr;
            regReq.num    <= cmdQ.num;
            regReq.wdata  <= dataQ;
         end else if (regReq.req && regAck) begin
            regReq.req <= 1'b0;
            accDoneQ   <= 1'b1;
            accDataQ   <= regRdata;
         end
      end
   end

   // Next block address; bus error still advances so the host can skip a hole
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         tempBreakAddrQ <= '0;
      end else if (memReq.req && (memAck || transferErrorAck)) begin
         tempBreakAddrQ <= memReq.addr + sizeStep(memReq.size);
      end
   end

   // Register slave; one wait state on every access
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
         addrAttrQ       <= ATTR_RESET;
      end else begin
         avs_waitrequest <= 1'b1;
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= '0;
            if (avs_address == OFS_ATTR) begin
               avs_readdata[ATTR_BITS-1:0] <= addrAttrQ;
               if (avs_write) begin
                  addrAttrQ <= avs_writedata[ATTR_BITS-1:0];
               end
            end else if (avs_address == OFS_STATUS) begin
               avs_readdata[STAT_BUSY]    <= (stateQ != ST_CMD);
               avs_readdata[STAT_DUMP_OK] <= dumpOkQ;
               avs_readdata[STAT_FILL_OK] <= fillOkQ;
               avs_readdata[STAT_ACCESS]  <= accessBusy;
            end else if (avs_address == OFS_TEMP_ADDR) begin
               avs_readdata <= tempBreakAddrQ;
            end
         end
      end
   end

endmodule // bdc_command_engine

// File: rtl/bdc_pkg.sv
package bdc_pkg;

   // Serial frame
   localparam int          FRAME_BITS     = 17;
   localparam logic [4:0]  FRAME_LAST     = 5'h10;

   // Operation field codes
   localparam logic [5:0]  OP_NOP         = 6'h00;
   localparam logic [5:0]  OP_GO          = 6'h03;
   localparam logic [5:0]  OP_MEM         = 6'h06;
   localparam logic [5:0]  OP_BLOCK       = 6'h07;
   localparam logic [5:0]  OP_REG         = 6'h08;

   // Operand size codes
   localparam logic [1:0]  SIZE_BYTE      = 2'h0;
   localparam logic [1:0]  SIZE_WORD      = 2'h1;
   localparam logic [1:0]  SIZE_LONG      = 2'h2;
   localparam logic [1:0]  SIZE_RSVD      = 2'h3;

   // Device responses, status/control bit on top
   localparam logic [16:0] RESP_NOT_READY = 17'h10000;
   localparam logic [16:0] RESP_BUS_ERR   = 17'h10001;
   localparam logic [16:0] RESP_ILLEGAL   = 17'h1ffff;
   localparam logic [16:0] RESP_DONE      = 17'h0ffff;

   // Register map, byte offsets
   localparam logic [3:0]  OFS_ATTR       = 4'h0;
   localparam logic [3:0]  OFS_STATUS     = 4'h4;
   localparam logic [3:0]  OFS_TEMP_ADDR  = 4'h8;
   localparam int          ATTR_BITS      = 5;
   localparam logic [4:0]  ATTR_RESET     = 5'h00;
   localparam int          STAT_BUSY      = 0;
   localparam int          STAT_DUMP_OK   = 1;
   localparam int          STAT_FILL_OK   = 2;
   localparam int          STAT_ACCESS    = 3;

   typedef struct packed {
      logic [5:0] op;
      logic       zero9;
      logic       rw;
      logic [1:0] size;
      logic [1:0] zero54;
      logic       isAddr;
      logic [2:0] num;
   } bdc_cmd_type;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [1:0]  size;
      logic [4:0]  attr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bdc_mem_req_type;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        isAddr;
      logic [2:0]  num;
      logic [31:0] wdata;
   } bdc_reg_req_type;

endpackage

// File: rtl/bdc_serial_shifter.sv
`timescale 1ns/1ps
module bdc_serial_shifter (
   input  wire logic        clk,
   input  wire logic        rstN,
   input  wire logic        serClkPin,
   input  wire logic        serInPin,
   input  wire logic [16:0] txWord,
   output logic             serOut,
   output logic             frameActive,
   output logic             rxValid,
   output logic [15:0]      rxWord
);
   import bdc_pkg::*;

   logic        clkS1, clkS2, clkS3;
   logic        inS1, inS2;
   logic [4:0]  bitCntQ;
   logic [16:0] txShQ;
   logic [15:0] rxShQ;
   logic        rise;

   // Pins pass two flops before any logic looks at them
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         clkS1 <= 1'b0;
         clkS2 <= 1'b0;
         clkS3 <= 1'b0;
         inS1  <= 1'b0;
         inS2  <= 1'b0;
      end else begin
         clkS1 <= serClkPin;
         clkS2 <= clkS1;
         clkS3 <= clkS2;
         inS1  <= serInPin;
         inS2  <= inS1;
      end
   end

   assign rise = clkS2 & ~clkS3;

   // Response is latched at the first edge, so it may change until then
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         bitCntQ     <= 5'h00;
         txShQ       <= '0;
         rxShQ       <= '0;
         serOut      <= 1'b0;
         frameActive <= 1'b0;
         rxValid     <= 1'b0;
         rxWord      <= '0;
      end else begin
         rxValid <= 1'b0;
         if (rise) begin
            rxShQ <= {rxShQ[14:0], inS2};
            if (bitCntQ == 5'h00) begin
               serOut      <= txWord[16];
               txShQ       <= {txWord[15:0], 1'b0};
               frameActive <= 1'b1;
            end else begin
               serOut <= txShQ[16];
               txShQ  <= {txShQ[15:0], 1'b0};
            end
            if (bitCntQ == FRAME_LAST) begin
               // Bit 16 from the host is ignored
               bitCntQ     <= 5'h00;
               rxValid     <= 1'b1;
               rxWord      <= {rxShQ[14:0], inS2};
               frameActive <= 1'b0;
            end else begin
               bitCntQ <= bitCntQ + 5'h01;
            end
         end
      end
   end

endmodule // bdc_serial_shifter
